//--- include/rst_pkg.sv
// constants for the reset source combiner and its cause/control register
// assumes a single 100 MHz system clock and an AXI4-Lite register port
//
// Summary of operation
// - Any active reset source drives the master system reset output.
// - Each reset source sets its own flag in the cause register.
// - Power-on reset clears all flags, setting power-on and brown-out bits.
// - Software may set or clear flags; writing never causes a reset.
// - Bit 15 records a trap conflict reset.
// - Bit 14 records illegal opcode, addressing, pointer or security reset.
// - Bit 9 records a configuration mismatch reset.
// - Bit 8 keeps the regulator active in sleep when one.
// - Bit 7 records a master clear pin reset.
// - Bit 6 records a reset caused by the reset instruction.
// - Bit 5 enables the watchdog; an unprogrammed fuse forces it on.
// - Bit 4 records a watchdog time-out.
// - Bit 3 records that the device has been in sleep.
// - Bit 2 records that the device has been in idle.
// - Bits 13 to 10 ignore writes and read zero.
// - System reset forces control bits; cause flags stay unaffected.
// - Bit 1 records a brown-out reset.
// - Bit 0 records a power-on reset.

package rst_pkg;

  // ----------------------------------------------------------------
  // register layout
  // ----------------------------------------------------------------
  localparam int unsigned REG_W = 16;
  localparam int unsigned POWERON_FLAG_BIT = 0;
  localparam int unsigned BROWNOUT_FLAG_BIT = 1;
  localparam int unsigned IDLE_FLAG_BIT = 2;
  localparam int unsigned SLEEP_FLAG_BIT = 3;
  localparam int unsigned WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int unsigned SOFT_WATCHDOG_ENABLE_BIT = 5;
  localparam int unsigned INSTRUCTION_RESET_FLAG_BIT = 6;
  localparam int unsigned PIN_RESET_FLAG_BIT = 7;
  localparam int unsigned REGULATOR_SLEEP_ACTIVE_BIT = 8;
  localparam int unsigned CONFIG_MISMATCH_FLAG_BIT = 9;
  localparam int unsigned ILLEGAL_CONDITION_FLAG_BIT = 14;
  localparam int unsigned TRAP_CONFLICT_FLAG_BIT = 15;

  // implemented bits, control bits and the power-on value
  localparam logic [15:0] IMPL_MASK = 16'hC3FF;
  localparam logic [15:0] CTRL_MASK = 16'h0120;
  localparam logic [15:0] POWERON_VALUE = 16'h0003;

  // ----------------------------------------------------------------
  // bus map and responses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] RESET_CAUSE_CONTROL_OFFSET = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

//--- src/reset_source_combiner_flags.sv
// reset source combiner with the reset cause/control register
// assumes all source inputs are synchronous to sys_clk and that nrst is the
// power-on reset of the register domain; registers reached over AXI4-Lite
`timescale 1ns/10ps

module reset_source_combiner_flags (
  input wire logic sys_clk,
  input wire logic nrst,
  // reset sources, active high except the pin
  input wire logic por_active,
  input wire logic brownout_active,
  input wire logic master_clear_pin_n,
  input wire logic reset_instruction,
  input wire logic watchdog_timeout,
  input wire logic config_mismatch,
  input wire logic trap_conflict,
  input wire logic illegal_condition,
  // power-saving state reports and the watchdog fuse
  input wire logic sleep_entered,
  input wire logic idle_entered,
  input wire logic watchdog_fuse_enable,
  // results
  output logic master_system_reset,
  output logic regulator_sleep_active,
  output logic watchdog_run,
  // AXI4-Lite slave
  input wire logic [rst_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rst_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rst_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rcc;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [15:0] set_vec;
  logic [15:0] rcc;
  logic aw_hit;
  logic ar_hit;
  logic commit;

  assign rcc = cur.rcc;

  // ----------------------------------------------------------------
  // source combining
  // ----------------------------------------------------------------
  // a plain OR so the reset follows a source with no clock of delay;
  // the output glitches only if a source itself glitches
  assign master_system_reset = por_active | brownout_active |
    !master_clear_pin_n | reset_instruction | watchdog_timeout |
    config_mismatch | trap_conflict | illegal_condition;

  // one flag position per source except power-on, which loads POWERON_VALUE, and per power-saving state
  always_comb begin
    set_vec = 16'h0000;
    set_vec[BROWNOUT_FLAG_BIT] = brownout_active;
    set_vec[IDLE_FLAG_BIT] = idle_entered;
    set_vec[SLEEP_FLAG_BIT] = sleep_entered;
    set_vec[WATCHDOG_TIMEOUT_FLAG_BIT] = watchdog_timeout;
    set_vec[INSTRUCTION_RESET_FLAG_BIT] = reset_instruction;
    set_vec[PIN_RESET_FLAG_BIT] = !master_clear_pin_n;
    set_vec[CONFIG_MISMATCH_FLAG_BIT] = config_mismatch;
    set_vec[ILLEGAL_CONDITION_FLAG_BIT] = illegal_condition;
    set_vec[TRAP_CONFLICT_FLAG_BIT] = trap_conflict;
  end

  // control outputs straight from the register bits; watchdog_run is also forced on by the fuse
  assign regulator_sleep_active = cur.rcc[REGULATOR_SLEEP_ACTIVE_BIT];
  assign watchdog_run = watchdog_fuse_enable |
    cur.rcc[SOFT_WATCHDOG_ENABLE_BIT];

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  // address and data are each held once taken; no new write is taken
  // until the response has been accepted
  assign s_axi_awready = !cur.aw_got && !cur.bvalid;
  assign s_axi_wready = !cur.w_got && !cur.bvalid;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rresp = cur.rresp;
  assign s_axi_rdata = {16'h0000, cur.rdata};

  // only the one aligned word decodes; low two bits are ignored
  assign aw_hit = cur.awaddr[ADDR_W-1:2] ==
    RESET_CAUSE_CONTROL_OFFSET[ADDR_W-1:2];
  assign ar_hit = s_axi_araddr[ADDR_W-1:2] ==
    RESET_CAUSE_CONTROL_OFFSET[ADDR_W-1:2];
  assign commit = cur.aw_got && cur.w_got && !cur.bvalid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // write address and data channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_cur.aw_got = 1'b1;
      next_cur.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_cur.w_got = 1'b1;
      next_cur.wdata = s_axi_wdata[15:0];
      next_cur.wstrb = s_axi_wstrb[1:0];
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end
    // commit the write once both halves are held; storing a flag is all
    // a write does, it never feeds the reset output
    if (commit) begin
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = aw_hit ? RESP_OKAY : RESP_DECERR;
      if (aw_hit && cur.wstrb[0]) begin
        next_cur.rcc[7:0] = cur.wdata[7:0];
      end
      if (aw_hit && cur.wstrb[1]) begin
        next_cur.rcc[15:8] = cur.wdata[15:8];
      end
    end
    // read channel, answered one cycle after the address is taken
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = ar_hit ? RESP_OKAY : RESP_DECERR;
      next_cur.rdata = ar_hit ? (cur.rcc & IMPL_MASK) : 16'h0000;
    end
    // a system reset returns the control bits to their reset value
    // while the cause flags ride through untouched
    if (master_system_reset) begin
      next_cur.rcc = next_cur.rcc & ~CTRL_MASK;
    end
    // hardware sets win over a software clear in the same cycle
    next_cur.rcc = next_cur.rcc | set_vec;
    // power-on wipes everything else and outranks all other sources
    if (por_active) begin
      next_cur.rcc = POWERON_VALUE;
    end
    // unimplemented bits never hold a one
    next_cur.rcc = next_cur.rcc & IMPL_MASK;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // nrst stands for power-on, so the register comes up as after one
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      cur.rcc <= POWERON_VALUE;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic any_write_hit;
  assign any_write_hit = commit && aw_hit;

  sequence s_quiet;
    !por_active && !master_system_reset && !any_write_hit &&
      !sleep_entered && !idle_entered;
  endsequence

  sequence s_full_write;
    commit && aw_hit && (cur.wstrb == 2'h3) && !master_system_reset &&
      !sleep_entered && !idle_entered;
  endsequence

  property p_reset_out;
    @(posedge sys_clk) disable iff (!nrst)
    (por_active || brownout_active || !master_clear_pin_n ||
      reset_instruction || watchdog_timeout || config_mismatch ||
      trap_conflict || illegal_condition) |-> master_system_reset;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("source active but system reset low");

  property p_flags_set;
    @(posedge sys_clk) disable iff (!nrst)
    (set_vec != 16'h0000) && !por_active |=>
      ((rcc & $past(set_vec)) == $past(set_vec));
  endproperty
  a_flags_set: assert property (p_flags_set)
    else $error("active source did not set its flag");

  property p_poweron;
    @(posedge sys_clk) disable iff (!nrst)
    por_active |-> master_system_reset ##1 (rcc == POWERON_VALUE);
  endproperty
  a_poweron: assert property (p_poweron)
    else $error("power-on did not raise reset and load its value");

  property p_poweron_value;
    @(posedge sys_clk) disable iff (!nrst)
    por_active |=> rcc == POWERON_VALUE;
  endproperty
  a_poweron_value: assert property (p_poweron_value)
    else $error("power-on did not leave only bits 1 and 0");

  property p_write_stores;
    @(posedge sys_clk) disable iff (!nrst)
    s_full_write |=> (rcc == ($past(cur.wdata) & IMPL_MASK)) &&
      !master_system_reset;
  endproperty
  a_write_stores: assert property (p_write_stores)
    else $error("register write not stored as written");

  property p_trap_flag;
    @(posedge sys_clk) disable iff (!nrst)
    trap_conflict && !por_active |=> rcc[TRAP_CONFLICT_FLAG_BIT] [*2];
  endproperty
  a_trap_flag: assert property (p_trap_flag)
    else $error("trap conflict flag not held");

  property p_unimpl_zero;
    @(posedge sys_clk) disable iff (!nrst)
    s_axi_rvalid |-> (s_axi_rdata[31:16] == 16'h0000) &&
      (s_axi_rdata[13:10] == 4'h0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bits read nonzero");

  property p_watchdog_run;
    @(posedge sys_clk) disable iff (!nrst)
    watchdog_run == (watchdog_fuse_enable || rcc[SOFT_WATCHDOG_ENABLE_BIT]);
  endproperty
  a_watchdog_run: assert property (p_watchdog_run)
    else $error("watchdog run ignores fuse or enable bit");

  property p_ctrl_cleared;
    @(posedge sys_clk) disable iff (!nrst)
    master_system_reset && !por_active |=> (rcc & CTRL_MASK) == 16'h0000;
  endproperty
  a_ctrl_cleared: assert property (p_ctrl_cleared)
    else $error("control bits survived a system reset");

  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
    s_quiet |=> $stable(rcc);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flags changed with no cause");

  property p_read_ack;
    @(posedge sys_clk) disable iff (!nrst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
      (s_axi_rresp == ($past(ar_hit) ? RESP_OKAY : RESP_DECERR));
  endproperty
  a_read_ack: assert property (p_read_ack)
    else $error("read not answered in one cycle");

  // ----------------------------------------------------------------
  // write answer, control bits and single flags
  // ----------------------------------------------------------------
  // the answer is judged against the decode held with the address,
  // so a late change on the address lines cannot hide a bad decode
  property p_write_resp;
    @(posedge sys_clk) disable iff (!nrst)
    commit |=> s_axi_bvalid &&
      (s_axi_bresp == ($past(aw_hit) ? RESP_OKAY : RESP_DECERR));
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write not answered one cycle after commit");

  // a system reset in the commit cycle clears the control bits,
  // so that case is left out here and covered by a_ctrl_cleared
  property p_regulator_out;
    @(posedge sys_clk) disable iff (!nrst)
    any_write_hit && cur.wstrb[1] && !master_system_reset |=>
      regulator_sleep_active == $past(cur.wdata[REGULATOR_SLEEP_ACTIVE_BIT]);
  endproperty
  a_regulator_out: assert property (p_regulator_out)
    else $error("regulator control does not follow a write");

  // the fuse can only force the watchdog on, never hold it off
  property p_watchdog_bit;
    @(posedge sys_clk) disable iff (!nrst)
    any_write_hit && cur.wstrb[0] && !master_system_reset |=>
      watchdog_run == (watchdog_fuse_enable ||
        $past(cur.wdata[SOFT_WATCHDOG_ENABLE_BIT]));
  endproperty
  a_watchdog_bit: assert property (p_watchdog_bit)
    else $error("watchdog enable does not follow a write");

  // wake and pin flags are caught at the edge after the request
  property p_sleep_flag;
    @(posedge sys_clk) disable iff (!nrst)
    sleep_entered && !por_active |=> rcc[SLEEP_FLAG_BIT];
  endproperty
  a_sleep_flag: assert property (p_sleep_flag)
    else $error("sleep flag not set");

  property p_idle_flag;
    @(posedge sys_clk) disable iff (!nrst)
    idle_entered && !por_active |=> rcc[IDLE_FLAG_BIT];
  endproperty
  a_idle_flag: assert property (p_idle_flag)
    else $error("idle flag not set");

  property p_pin_flag;
    @(posedge sys_clk) disable iff (!nrst)
    !master_clear_pin_n && !por_active |=> rcc[PIN_RESET_FLAG_BIT];
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("pin reset flag not set");

  // with every source quiet nothing, a register write included, may
  // raise the system reset
  property p_quiet_no_reset;
    @(posedge sys_clk) disable iff (!nrst)
    (!por_active && !brownout_active && master_clear_pin_n &&
      !reset_instruction && !watchdog_timeout && !config_mismatch &&
      !trap_conflict && !illegal_condition) |-> !master_system_reset;
  endproperty
  a_quiet_no_reset: assert property (p_quiet_no_reset)
    else $error("system reset high with every source quiet");

endmodule

//--- sim/reset_source_model.sv
// far-side model: on-chip reset sources and power-state reports
// assumes the bench picks sources through a one-hot fire vector
`timescale 1ns/10ps

module reset_source_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [9:0] fire,
  output logic por_active,
  output logic brownout_active,
  output logic master_clear_pin_n,
  output logic reset_instruction,
  output logic watchdog_timeout,
  output logic config_mismatch,
  output logic trap_conflict,
  output logic illegal_condition,
  output logic sleep_entered,
  output logic idle_entered
);
  logic [9:0] src;

  // sources move only after an edge, like synchronised detectors;
  // the pin idles high and goes low to request a reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      src <= 10'h004;
    end else begin
      src <= fire ^ 10'h004;
    end
  end

  assign {idle_entered, sleep_entered, illegal_condition, trap_conflict,
    config_mismatch, watchdog_timeout, reset_instruction, master_clear_pin_n,
    brownout_active, por_active} = src;
endmodule

//--- sim/testbench.sv
// self-checking bench for the reset source combiner
// assumes rst_pkg is compiled first; sources come from the source model
`timescale 1ns/10ps

module testbench;
  import rst_pkg::*;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic [9:0] fire = 10'h000;
  logic watchdog_fuse_enable = 1'h0;
  logic por_active, brownout_active, master_clear_pin_n, reset_instruction;
  logic watchdog_timeout, config_mismatch, trap_conflict, illegal_condition;
  logic sleep_entered, idle_entered;
  logic master_system_reset, regulator_sleep_active, watchdog_run;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, aw_hs, w_hs, ar_hs;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_q;
  int err_count = 0;
  int tests_run = 0;
  // row i fires source i: register image and reset output expected
  logic [15:0] row_exp [10] = '{16'h0003, 16'h0002, 16'h0080, 16'h0040,
    16'h0010, 16'h0200, 16'h8000, 16'h4000, 16'h0008, 16'h0004};
  logic [9:0] row_rst = 10'h0FF;

  initial forever #5 sys_clk = ~sys_clk;

  reset_source_combiner_flags DUT (.sys_clk, .nrst, .por_active,
    .brownout_active, .master_clear_pin_n, .reset_instruction,
    .watchdog_timeout, .config_mismatch, .trap_conflict, .illegal_condition,
    .sleep_entered, .idle_entered, .watchdog_fuse_enable,
    .master_system_reset, .regulator_sleep_active, .watchdog_run,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  reset_source_model model (.sys_clk, .nrst, .fire, .por_active,
    .brownout_active, .master_clear_pin_n, .reset_instruction,
    .watchdog_timeout, .config_mismatch, .trap_conflict, .illegal_condition,
    .sleep_entered, .idle_entered);

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task test_done;
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // handshakes are judged at the falling edge, where the values that the
  // next rising edge samples are already settled, so no race with the dut
  task wait_ans(input logic is_rd);
    int n;
    logic done;
    n = 0;
    done = 1'h0;
    while (!done && n < 50) begin
      @(negedge sys_clk);
      done = is_rd ? s_axi_rvalid : s_axi_bvalid;
      resp = is_rd ? s_axi_rresp : s_axi_bresp;
      rd_q = s_axi_rdata;
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs = s_axi_wvalid & s_axi_wready;
      ar_hs = s_axi_arvalid & s_axi_arready;
      @(posedge sys_clk);
      if (aw_hs) s_axi_awvalid <= 1'h0;
      if (w_hs) s_axi_wvalid <= 1'h0;
      if (ar_hs) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    if (!done) begin
      err_count++;
      test_done();
    end
  endtask

  task wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
          input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    wait_ans(1'h0);
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  task rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    wait_ans(1'h1);
    chk("rdata", {16'h0000, e}, rd_q);
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask

  // one-cycle source request; the reset output is combinational
  task pulse(input logic [9:0] v, input logic r);
    @(posedge sys_clk);
    fire <= v;
    @(posedge sys_clk);
    fire <= 10'h000;
    #1;
    chk("master_system_reset", {31'h0, r}, {31'h0, master_system_reset});
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'h1;
    rd(12'h000, 16'h0003, RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      wr(12'h000, 16'h0000, 4'h3, RESP_OKAY);
      pulse(10'h001 << i, row_rst[i]);
      rd(12'h000, row_exp[i], RESP_OKAY);
    end
    // software sets every flag without resetting anything
    wr(12'h000, 16'hFFFF, 4'h3, RESP_OKAY);
    #1;
    chk("master_system_reset", 32'h0, {31'h0, master_system_reset});
    rd(12'h000, 16'hC3FF, RESP_OKAY);
    chk("regulator", 32'h1, {31'h0, regulator_sleep_active});
    chk("watchdog_run", 32'h1, {31'h0, watchdog_run});
    // a trap reset drops the control bits but keeps every flag
    pulse(10'h040, 1'h1);
    rd(12'h000, 16'hC2DF, RESP_OKAY);
    wr(12'h000, 16'h0000, 4'h3, RESP_OKAY);
    #1;
    chk("regulator", 32'h0, {31'h0, regulator_sleep_active});
    chk("watchdog_run", 32'h0, {31'h0, watchdog_run});
    @(posedge sys_clk);
    watchdog_fuse_enable <= 1'h1;
    #1;
    chk("watchdog_run", 32'h1, {31'h0, watchdog_run});
    @(posedge sys_clk);
    watchdog_fuse_enable <= 1'h0;
    // byte lane 0 only, then an unmapped place
    wr(12'h000, 16'hFFFF, 4'h1, RESP_OKAY);
    rd(12'h000, 16'h00FF, RESP_OKAY);
    wr(12'h004, 16'hFFFF, 4'h3, RESP_DECERR);
    rd(12'h004, 16'h0000, RESP_DECERR);
    rd(12'h000, 16'h00FF, RESP_OKAY);
    // byte lane 1 only: upper byte lands, lower byte kept
    wr(12'h000, 16'hFFFF, 4'h2, RESP_OKAY);
    rd(12'h000, 16'hC3FF, RESP_OKAY);
    chk("regulator", 32'h1, {31'h0, regulator_sleep_active});
    // power-on reset in mid-run
    @(posedge sys_clk);
    nrst <= 1'h0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'h1;
    rd(12'h000, 16'h0003, RESP_OKAY);
    chk("regulator", 32'h0, {31'h0, regulator_sleep_active});
    test_done();
  end
endmodule
